// *** pkg/susp_pin_pkg.sv ***
package susp_pin_pkg;

    // -------------------------------------------------------------
    // Register indices and byte addresses
    // -------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] IDX_SUSPEND_LEVEL   = 12'h06A;
    localparam logic [11:0] IDX_SUSPEND_DRIVE   = 12'h06B;
    localparam logic [11:0] IDX_CHIP_REVISION   = 12'h260;
    localparam logic [11:0] IDX_USB_INDICATOR   = 12'h262;
    localparam logic [11:0] ADDR_SUSPEND_LEVEL  = 12'(IDX_SUSPEND_LEVEL * 4);
    localparam logic [11:0] ADDR_SUSPEND_DRIVE  = 12'(IDX_SUSPEND_DRIVE * 4);
    localparam logic [11:0] ADDR_CHIP_REVISION  = 12'(IDX_CHIP_REVISION * 4);
    localparam logic [11:0] ADDR_USB_INDICATOR  = 12'(IDX_USB_INDICATOR * 4);

    // -------------------------------------------------------------
    // Field layout
    // -------------------------------------------------------------
    localparam int unsigned PIN_N        = 14;
    localparam int unsigned OVERRIDE_BIT = 15;
    localparam int unsigned IND_LEVEL_BIT = 13;
    localparam int unsigned IND_SEL_LSB  = 10;
    localparam logic [15:0] PIN_MASK     = 16'h3CCF;
    localparam logic [15:0] DRIVE_MASK   = 16'hBCCF;

    // -------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------
    localparam logic [15:0] SUSPEND_LEVEL_RST = 16'h0000;
    localparam logic [15:0] SUSPEND_DRIVE_RST = 16'h0000;
    localparam logic [2:0]  IND_SEL_RST       = 3'h0;

    // -------------------------------------------------------------
    // Indicator select codes
    // -------------------------------------------------------------
    localparam logic [2:0] SEL_HI_SUSP_RST  = 3'h0;
    localparam logic [2:0] SEL_HI_SUSP      = 3'h1;
    localparam logic [2:0] SEL_HI_SUSP_CFG  = 3'h2;
    localparam logic [2:0] SEL_HI_RST       = 3'h3;
    localparam logic [2:0] SEL_HI_SUSP_RST2 = 3'h4;
    localparam logic [2:0] SEL_LO_SUSP      = 3'h5;
    localparam logic [2:0] SEL_LO_SUSP_CFG  = 3'h6;
    localparam logic [2:0] SEL_LO_RST       = 3'h7;

    // -------------------------------------------------------------
    // Types
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_RUN      = 2'b00,
        MODE_HOLD     = 2'b01,
        MODE_OVERRIDE = 2'b10
    } mode_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_type;

    typedef struct packed {
        logic [13:0] level;
        logic [13:0] open_drain;
    } pin_drive_type;

    typedef struct packed {
        logic        suspended;
        logic        bus_reset;
        logic        configured;
        logic        high_power;
    } usb_state_type;

endpackage

// *** design/indicator_select.sv ***
module indicator_select (
    // Selection
    input  wire logic [2:0]                  sel,
    // USB condition
    input  wire susp_pin_pkg::usb_state_type usb,
    // Result
    output logic                             level
);

    import susp_pin_pkg::*;

    logic susp_or_cfg;

    // Unconfigured counts only for the high power class
    assign susp_or_cfg = usb.suspended | (usb.high_power & ~usb.configured);

    always_comb begin
        unique case (sel)
            SEL_HI_SUSP_RST:  level = usb.suspended | usb.bus_reset;
            SEL_HI_SUSP:      level = usb.suspended;
            SEL_HI_SUSP_CFG:  level = susp_or_cfg;
            SEL_HI_RST:       level = usb.bus_reset;
            SEL_HI_SUSP_RST2: level = usb.suspended | usb.bus_reset;
            SEL_LO_SUSP:      level = ~usb.suspended;
            SEL_LO_SUSP_CFG:  level = ~susp_or_cfg;
            SEL_LO_RST:       level = ~usb.bus_reset;
        endcase
    end

endmodule // indicator_select

// *** design/suspend_pin_control.sv ***
// What this block does
// - Override clear: outputs keep present level and driver type on suspend.
// - Override set: on suspend, outputs take programmed level and driver type.
// - Modem-status drive bits: 0 push-pull, 1 open drain.
// - Transmit, direction, CTS, RTS, clock drive bits: 0 push-pull, 1 open drain.
// - Indicator level field reads live pin level; writes ignored.
// - Select 000 suspend or reset, 001 suspend, 011 reset, all high.
// - Select 010: suspend, plus unconfigured when high power, drives high.
// - Select 100 behaves exactly like 000.
// - 101 low on suspend, 111 low on reset, 110 inverse of 010.
// - Drive register and indicator select reset to zero.
// - Level register bit set gives 1, clear gives 0, under override.
module suspend_pin_control #(
    parameter logic [15:0] CHIP_REVISION_CODE = 16'h00A5 // Arbitrary value
)(
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire susp_pin_pkg::apb_req_type   apb_req,
    output susp_pin_pkg::apb_rsp_type        apb_rsp,
    // USB condition from the device core
    input  wire susp_pin_pkg::usb_state_type usb,
    // Normal functional pin drive
    input  wire susp_pin_pkg::pin_drive_type func_drive,
    // Pin drive towards the pads
    output susp_pin_pkg::pin_drive_type      pin_drive,
    output logic                             usb_indicator_two
);

    import susp_pin_pkg::*;

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        mode_type      mode;
        logic [15:0]   level_ctl;
        logic [15:0]   drive_ctl;
        logic [2:0]    ind_sel;
        pin_drive_type drive;
        logic          ind;
        logic          susp_d;
        apb_rsp_type   rsp;
    } state_type;

    state_type state_ff;
    state_type nxt_state;
    logic      ind_level;

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [15:0] merge_write(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0]  strb,
        input logic [15:0] mask
    );
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        return (old & ~lanes) | (wdata[15:0] & lanes);
    endfunction

    function automatic logic addr_hit(
        input logic [11:0] addr
    );
        return (addr == ADDR_SUSPEND_LEVEL) || (addr == ADDR_SUSPEND_DRIVE)
            || (addr == ADDR_CHIP_REVISION) || (addr == ADDR_USB_INDICATOR);
    endfunction

    // -------------------------------------------------------------
    // Indicator decode
    // -------------------------------------------------------------
    indicator_select u_indicator_select (
        .sel   (state_ff.ind_sel),
        .usb   (usb),
        .level (ind_level)
    );

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    logic        setup;
    logic        access_done;
    logic [15:0] rd_word;
    pin_drive_type ovr_drive;

    assign setup       = apb_req.psel & ~apb_req.penable;
    assign access_done = apb_req.psel & apb_req.penable & state_ff.rsp.pready;

    assign ovr_drive.level      = state_ff.level_ctl[PIN_N-1:0];
    assign ovr_drive.open_drain = state_ff.drive_ctl[PIN_N-1:0];

    always_comb begin
        unique case (apb_req.paddr)
            ADDR_SUSPEND_LEVEL: rd_word = state_ff.level_ctl;
            ADDR_SUSPEND_DRIVE: rd_word = state_ff.drive_ctl;
            ADDR_CHIP_REVISION: rd_word = CHIP_REVISION_CODE;
            ADDR_USB_INDICATOR: begin
                rd_word = 16'h0000;
                rd_word[IND_LEVEL_BIT] = state_ff.ind;
                rd_word[IND_SEL_LSB +: 3] = state_ff.ind_sel;
            end
            default:            rd_word = 16'h0000;
        endcase
    end

    always_comb begin
        nxt_state        = state_ff;
        nxt_state.susp_d = usb.suspended;
        nxt_state.ind    = ind_level;

        // Bus response: no wait state, yet every answer comes from a flop
        if (access_done) begin
            nxt_state.rsp = '0;
        end else if (setup) begin
            nxt_state.rsp.pready  = 1'b1;
            nxt_state.rsp.pslverr = ~addr_hit(apb_req.paddr);
            nxt_state.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000
                                                   : {16'h0000, rd_word};
        end

        // Register writes land on the completing edge only
        if (access_done && apb_req.pwrite) begin
            unique case (apb_req.paddr)
                ADDR_SUSPEND_LEVEL: begin
                    nxt_state.level_ctl = merge_write(state_ff.level_ctl,
                        apb_req.pwdata, apb_req.pstrb, PIN_MASK);
                end
                ADDR_SUSPEND_DRIVE: begin
                    nxt_state.drive_ctl = merge_write(state_ff.drive_ctl,
                        apb_req.pwdata, apb_req.pstrb, DRIVE_MASK);
                end
                ADDR_USB_INDICATOR: begin
                    // Level bit is read only; only the select moves
                    if (apb_req.pstrb[1]) begin
                        nxt_state.ind_sel =
                            apb_req.pwdata[IND_SEL_LSB +: 3];
                    end
                end
                default: begin
                end
            endcase
        end

        // Suspend handling
        unique case (state_ff.mode)
            MODE_RUN: begin
                nxt_state.drive = func_drive;
                if (usb.suspended && !state_ff.susp_d) begin
                    if (state_ff.drive_ctl[OVERRIDE_BIT]) begin
                        nxt_state.mode  = MODE_OVERRIDE;
                        nxt_state.drive = ovr_drive;
                    end else begin
                        nxt_state.mode  = MODE_HOLD;
                        nxt_state.drive = state_ff.drive;
                    end
                end
            end
            MODE_HOLD: begin
                if (!usb.suspended) begin
                    nxt_state.mode  = MODE_RUN;
                    nxt_state.drive = func_drive;
                end
            end
            MODE_OVERRIDE: begin
                nxt_state.drive = ovr_drive;
                if (!usb.suspended) begin
                    nxt_state.mode  = MODE_RUN;
                    nxt_state.drive = func_drive;
                end
            end
            default: begin
                nxt_state.mode  = MODE_RUN;
                nxt_state.drive = func_drive;
            end
        endcase
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff.mode      <= MODE_RUN;
            state_ff.level_ctl <= SUSPEND_LEVEL_RST;
            state_ff.drive_ctl <= SUSPEND_DRIVE_RST;
            state_ff.ind_sel   <= IND_SEL_RST;
            state_ff.drive     <= '0;
            state_ff.ind       <= 1'b0;
            state_ff.susp_d    <= 1'b0;
            state_ff.rsp       <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign apb_rsp           = state_ff.rsp;
    assign pin_drive         = state_ff.drive;
    assign usb_indicator_two = state_ff.ind;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [15:0] prev_level_ctl;
    logic [15:0] prev_drive_ctl;
    assign prev_level_ctl = state_ff.level_ctl;
    assign prev_drive_ctl = state_ff.drive_ctl;

    sequence s_enter_suspend;
        state_ff.mode == MODE_RUN && usb.suspended && !state_ff.susp_d;
    endsequence

    sequence s_ind_read;
        setup && !apb_req.pwrite && apb_req.paddr == ADDR_USB_INDICATOR;
    endsequence

    AST_HOLD_KEEPS: assert property (
        s_enter_suspend ##0 !state_ff.drive_ctl[OVERRIDE_BIT] |=>
            state_ff.mode == MODE_HOLD && $stable(pin_drive)
    ) else $error("pins changed on suspend entry without override");

    AST_HOLD_STABLE: assert property (
        state_ff.mode == MODE_HOLD && usb.suspended |=> $stable(pin_drive)
    ) else $error("held pins moved during suspend");

    AST_OVR_LEVEL: assert property (
        s_enter_suspend ##0 state_ff.drive_ctl[OVERRIDE_BIT] |=>
            pin_drive.level == $past(prev_level_ctl[PIN_N-1:0])
    ) else $error("override level not applied");

    AST_OVR_TYPE: assert property (
        s_enter_suspend ##0 state_ff.drive_ctl[OVERRIDE_BIT] |=>
            pin_drive.open_drain == $past(prev_drive_ctl[PIN_N-1:0])
    ) else $error("override driver type not applied");

    AST_EXIT_RUN: assert property (
        state_ff.mode != MODE_RUN && !usb.suspended |=>
            state_ff.mode == MODE_RUN
            && pin_drive == $past(func_drive)
    ) else $error("outputs not restored on resume");

    AST_IND_SUSP: assert property (
        state_ff.ind_sel == SEL_HI_SUSP && usb.suspended |=> usb_indicator_two
    ) else $error("indicator not high in suspend");

    AST_IND_RST: assert property (
        state_ff.ind_sel == SEL_HI_SUSP_RST2 && usb.bus_reset
            |=> usb_indicator_two
    ) else $error("indicator not high in bus reset");

    AST_IND_CFG: assert property (
        state_ff.ind_sel == SEL_HI_SUSP_CFG && usb.high_power
            && !usb.configured |=> usb_indicator_two
    ) else $error("indicator not high while unconfigured");

    AST_IND_LOW: assert property (
        state_ff.ind_sel == SEL_LO_RST && usb.bus_reset |=> !usb_indicator_two
    ) else $error("indicator not low in bus reset");

    AST_IND_BOTH: assert property (
        state_ff.ind_sel == SEL_HI_SUSP_RST
            && (usb.suspended || usb.bus_reset) |=> usb_indicator_two
    ) else $error("indicator not high in suspend or bus reset");

    AST_IND_HI_RST: assert property (
        state_ff.ind_sel == SEL_HI_RST && usb.bus_reset |=> usb_indicator_two
    ) else $error("reset-only indicator not high in bus reset");

    AST_IND_IDLE: assert property (
        state_ff.ind_sel == SEL_HI_SUSP && !usb.suspended
            |=> !usb_indicator_two
    ) else $error("indicator high outside suspend");

    AST_IND_LO_SUSP: assert property (
        state_ff.ind_sel == SEL_LO_SUSP && usb.suspended
            |=> !usb_indicator_two
    ) else $error("indicator not low in suspend");

    AST_IND_LO_CFG: assert property (
        state_ff.ind_sel == SEL_LO_SUSP_CFG && usb.high_power
            && !usb.configured |=> !usb_indicator_two
    ) else $error("indicator not low while unconfigured");

    // Override keeps following the registers, one cycle behind
    AST_OVR_TRACK: assert property (
        state_ff.mode == MODE_OVERRIDE && usb.suspended |=>
            pin_drive.level == $past(prev_level_ctl[PIN_N-1:0])
            && pin_drive.open_drain == $past(prev_drive_ctl[PIN_N-1:0])
    ) else $error("override pins do not follow the registers");

    AST_RSP_ONE: assert property (
        apb_rsp.pready |=> !apb_rsp.pready
    ) else $error("bus answer stood longer than one cycle");

    AST_LEVEL_READ: assert property (
        s_ind_read |=> apb_rsp.pready
            && apb_rsp.prdata[IND_LEVEL_BIT] == $past(usb_indicator_two)
    ) else $error("indicator level readback wrong");

    AST_RO_REVISION: assert property (
        setup && !apb_req.pwrite && apb_req.paddr == ADDR_CHIP_REVISION
            |=> apb_rsp.prdata[15:0] == CHIP_REVISION_CODE
    ) else $error("revision readback wrong");

    AST_UNMAPPED: assert property (
        setup && !addr_hit(apb_req.paddr) |=> apb_rsp.pready && apb_rsp.pslverr
    ) else $error("unmapped address not flagged");

endmodule // suspend_pin_control

// *** tb/suspend_pin_control_usb_status_tb.sv ***
module suspend_pin_control_usb_status_tb import susp_pin_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    localparam logic [15:0] REV = 16'h00A5; // Arbitrary value
    logic          pclk;
    logic          presetn;
    apb_req_type   req;
    apb_rsp_type   rsp;
    usb_state_type usb;
    pin_drive_type func_drive;
    pin_drive_type pin_drive;
    logic          ind;
    int            err_total;
    int            check_count;

    suspend_pin_control #(.CHIP_REVISION_CODE(REV)) u_dut (
        .pclk              (pclk),
        .presetn           (presetn),
        .apb_req           (req),
        .apb_rsp           (rsp),
        .usb               (usb),
        .func_drive        (func_drive),
        .pin_drive         (pin_drive),
        .usb_indicator_two (ind)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic test_done;
        $display("Counts: %0d checks, %0d errors", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Entered just after a rising edge; a bounded wait guards pready
    task automatic apb(input logic is_wr, input logic [11:0] a,
                       input logic [15:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= is_wr;
        req.paddr   <= a;
        req.pwdata  <= {16'h0000, wd};
        // Reads carry no strobes, as the bus protocol asks
        req.pstrb   <= is_wr ? 4'h3 : 4'h0;
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            err_total++;
            $display("BAD %0t no pready", $time);
            test_done();
        end
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
    endtask

    // Error flag rides in bit 31 so one compare covers both
    task automatic rdchk(input logic [11:0] a, input logic [15:0] exp,
                         input logic e);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 16'h0000, rd, er);
        chk({er, rd[30:0]}, {e, 15'h0000, exp}, "register read");
    endtask

    function automatic logic ind_exp(input logic [2:0] s,
                                     input usb_state_type u);
        logic sr;
        logic cf;
        sr = u.suspended | u.bus_reset;
        cf = u.suspended | (u.high_power & ~u.configured);
        case (s)
            3'h0, 3'h4: return sr;
            3'h1:       return u.suspended;
            3'h2:       return cf;
            3'h3:       return u.bus_reset;
            3'h5:       return ~u.suspended;
            3'h6:       return ~cf;
            default:    return ~u.bus_reset;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] rd;
        logic        er;
        rdchk(ADDR_SUSPEND_DRIVE, 16'h0000, 1'b0);
        rdchk(ADDR_USB_INDICATOR, 16'h0000, 1'b0);
        rdchk(ADDR_SUSPEND_LEVEL, SUSPEND_LEVEL_RST, 1'b0);
        rdchk(ADDR_CHIP_REVISION, REV, 1'b0);
        wr(ADDR_CHIP_REVISION, 16'hFFFF);
        rdchk(ADDR_CHIP_REVISION, REV, 1'b0);
        apb(1'b0, 12'h004, 16'h0000, rd, er);
        chk({31'h0, er}, 32'h1, "unmapped error");
        // Every writable bit set, reserved bits left at zero
        wr(ADDR_SUSPEND_LEVEL, PIN_MASK);
        rdchk(ADDR_SUSPEND_LEVEL, PIN_MASK, 1'b0);
        wr(ADDR_SUSPEND_DRIVE, DRIVE_MASK);
        rdchk(ADDR_SUSPEND_DRIVE, DRIVE_MASK, 1'b0);
        // Level bit is live: a written 1 with the pin low reads 0
        wr(ADDR_USB_INDICATOR, 16'h2000);
        rdchk(ADDR_USB_INDICATOR, 16'h0000, 1'b0);
        // Select 111 with no bus reset: pin high
        wr(ADDR_USB_INDICATOR, 16'h1C00);
        rdchk(ADDR_USB_INDICATOR, 16'h3C00, 1'b0);
        wr(ADDR_SUSPEND_DRIVE, 16'h0000);
        wr(ADDR_USB_INDICATOR, 16'h0000);
    endtask

    task automatic t_hold;
        func_drive <= 28'hA5C3E1B;
        tick(2);
        usb.suspended <= 1'b1;
        tick(1);
        func_drive <= 28'h35A7C24;
        tick(3);
        chk({4'h0, pin_drive}, 32'h0A5C3E1B, "held pins");
        usb.suspended <= 1'b0;
        tick(3);
        chk({4'h0, pin_drive}, 32'h035A7C24, "pins after resume");
    endtask

    task automatic t_override;
        logic [15:0] lv [2];
        logic [15:0] dv [2];
        lv[0] = 16'h2845;
        dv[0] = 16'h9483;
        lv[1] = 16'h148A;
        dv[1] = 16'hA84C;
        // Complementary patterns so every writable pin sees both 0 and 1
        for (int p = 0; p < 2; p++) begin
            func_drive <= 28'h6B1D293;
            wr(ADDR_SUSPEND_LEVEL, lv[p]);
            wr(ADDR_SUSPEND_DRIVE, dv[p]);
            usb.suspended <= 1'b1;
            tick(3);
            chk({4'h0, pin_drive}, {4'h0, lv[p][13:0] & PIN_MASK[13:0],
                dv[p][13:0] & PIN_MASK[13:0]}, "override pins");
            usb.suspended <= 1'b0;
            tick(3);
            chk({4'h0, pin_drive}, 32'h06B1D293, "pins restored");
        end
        wr(ADDR_SUSPEND_DRIVE, 16'h0000);
    endtask

    task automatic t_indicator;
        logic exp;
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_USB_INDICATOR, {3'b000, s[2:0], 10'h000});
            for (int c = 0; c < 16; c++) begin
                usb <= usb_state_type'(c[3:0]);
                tick(2);
                exp = ind_exp(s[2:0], usb_state_type'(c[3:0]));
                chk({31'h0, ind}, {31'h0, exp}, "indicator");
            end
            rdchk(ADDR_USB_INDICATOR, {2'b00, exp, s[2:0], 10'h000},
                  1'b0);
        end
        usb <= '0;
        tick(2);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        err_total   = 0;
        check_count = 0;
        presetn     = 1'b0;
        req         = '0;
        usb         = '0;
        func_drive  = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_hold();
        t_override();
        t_indicator();
        test_done();
    end
endmodule // suspend_pin_control_usb_status_tb
